/* File: common/tra_pkg.sv */
// Purpose: shared constants and types for the exception return address picker
// Assumes: one AHB-Lite slave, 32-bit words, one clock
// Notes:   register offsets are byte addresses
package tra_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  TRA_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  TRA_COUNT_OFS  = 8'h04;
    localparam logic [7:0]  TRA_LAST_OFS   = 8'h08;
    localparam int          TRA_TRACE_BIT  = 0;
    localparam int          TRA_DATA_BIT   = 1;
    localparam logic [1:0]  TRA_CTRL_RESET = 2'h0;
    localparam logic [15:0] TRA_COUNT_RESET = 16'h0000;
    localparam logic [31:0] TRA_ADDR_RESET = 32'h00000000;
    localparam logic [1:0]  TRA_HTRANS_NONSEQ = 2'h2;
    // ----------------------------------------------------------------
    // Address constants
    // ----------------------------------------------------------------
    localparam logic [31:0] TRA_TAIL_ADDR  = 32'h0FFFFFFE;
    localparam logic [31:0] TRA_STEP_HALF  = 32'h00000002;
    localparam logic [31:0] TRA_STEP_WORD  = 32'h00000004;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        EXC_RESET, EXC_IRQ, EXC_FIQ, EXC_TRAP, EXC_TRAPPED_EXC,
        EXC_CALL, EXC_INST_FAULT, EXC_DATA_FAULT, EXC_INST_DEBUG,
        EXC_DATA_DEBUG, EXC_ALIGNMENT, EXC_SYSTEM_ERROR, EXC_DEBUG_HALT,
        EXC_NMI, EXC_HARD_FAULT, EXC_MEM_MANAGE, EXC_BUS_FAULT,
        EXC_USAGE_FAULT, EXC_SECURE_FAULT, EXC_DEBUG_MONITOR, EXC_SUPERVISOR_CALL_EXCEPTION,
        EXC_EXT_IRQ, EXC_PENDED_SUPERVISOR_CALL, EXC_SYSTEM_TICK_EXCEPTION, EXC_LAZY_FP, EXC_LOCKUP
    } tra_exc_type;
    typedef enum logic [2:0] {
        POL_UNKNOWN, POL_NEXT, POL_CAUSE, POL_CALL,
        POL_LOCKUP, POL_ELR, POL_LR_M4, POL_DLR
    } tra_policy_type;
    typedef struct packed {
        logic        valid;
        tra_exc_type exc;
        logic        mcu;
        logic        mcu_v2;
        logic        a64_cap;
        logic        to_64;
        logic        tail;
        logic        ici_nz;
        logic        insn32;
        logic        ici_plus4;
        logic        bus_sync;
        logic        imprecise;
        logic        nid_secure_off;
        logic        lazy_secure;
        logic        prev_traced;
        logic [31:0] addr_next;
        logic [31:0] addr_cause;
        logic [31:0] addr_call;
        logic [31:0] addr_lockup;
        logic [31:0] exception_link_register;
        logic [31:0] lr;
        logic [31:0] debug_link_register;
    } tra_core_type;
    typedef struct packed {
        logic        valid;
        tra_exc_type exc;
        logic [31:0] addr;
        logic        addr_unknown;
        logic        ctx_unknown;
        logic        no_exec;
        logic        prev_unknown;
        logic        handler_hidden;
    } tra_elem_type;
    typedef struct packed {
        logic [1:0]   ctrl;
        logic [15:0]  count;
        logic [31:0]  last_addr;
        tra_elem_type elem;
        logic         dp_wr;
        logic [7:0]   dp_addr;
        logic [31:0]  hrdata;
        logic         hready;
    } tra_state_type;
endpackage

/* File: src/tra_top.sv */
// Purpose: picks the return address for each traced exception element
// Assumes: core inputs are synchronous to hclk and valid for one cycle
// Notes:   element leaves one cycle after the core reports the exception
`timescale 1ns/1ps
module tra_top
    import tra_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    input  wire tra_core_type core,
    output tra_elem_type      elem
);
    // ----------------------------------------------------------------
    // Lookup
    // ----------------------------------------------------------------
    function automatic tra_policy_type pick_policy(input tra_core_type c);
        tra_policy_type p;
        p = POL_NEXT;
        unique case (c.exc)
            EXC_RESET: p = POL_UNKNOWN;
            EXC_TRAP, EXC_TRAPPED_EXC: p = POL_CAUSE;
            EXC_CALL, EXC_SUPERVISOR_CALL_EXCEPTION: p = POL_CALL;
            EXC_INST_FAULT, EXC_DATA_FAULT, EXC_INST_DEBUG,
            EXC_DATA_DEBUG, EXC_ALIGNMENT: p = POL_CAUSE;
            EXC_MEM_MANAGE, EXC_USAGE_FAULT: p = POL_CAUSE;
            EXC_BUS_FAULT: p = c.bus_sync ? POL_CAUSE : POL_NEXT;
            EXC_LOCKUP: p = POL_LOCKUP;
            EXC_SYSTEM_ERROR: begin
                if (c.imprecise && !c.mcu) begin
                    p = c.to_64 ? POL_ELR : POL_LR_M4;
                end
            end
            EXC_DEBUG_HALT: begin
                if (c.imprecise || (!c.mcu && c.a64_cap)) begin
                    p = POL_DLR;
                end
            end
            EXC_IRQ, EXC_FIQ, EXC_NMI, EXC_HARD_FAULT, EXC_SECURE_FAULT,
            EXC_DEBUG_MONITOR, EXC_EXT_IRQ, EXC_PENDED_SUPERVISOR_CALL, EXC_SYSTEM_TICK_EXCEPTION,
            EXC_LAZY_FP: p = POL_NEXT;
            default: p = POL_NEXT;
        endcase
        return p;
    endfunction

    function automatic logic [31:0] resolve_addr(input tra_core_type c,
                                                 input tra_policy_type p);
        logic [31:0] a;
        a = c.addr_next;
        unique case (p)
            POL_UNKNOWN: a = TRA_ADDR_RESET;
            POL_NEXT: a = c.addr_next;
            POL_CAUSE: a = c.addr_cause;
            POL_CALL: a = c.addr_call;
            POL_LOCKUP: a = c.addr_lockup;
            POL_ELR: a = c.exception_link_register;
            POL_LR_M4: a = c.lr - TRA_STEP_WORD;
            POL_DLR: a = c.debug_link_register;
        endcase
        // Continued instruction must not look fully retired
        if (p == POL_NEXT && c.ici_nz) begin
            a = c.addr_cause + ((c.insn32 && c.ici_plus4) ?
                                TRA_STEP_WORD : TRA_STEP_HALF);
        end
        if (c.mcu && c.tail && p != POL_UNKNOWN) begin
            a = TRA_TAIL_ADDR;
        end
        return a;
    endfunction

    // ----------------------------------------------------------------
    // Trace gating
    // ----------------------------------------------------------------
    tra_state_type  st_reg;
    tra_state_type  st_next;
    tra_policy_type pol;
    logic           take;
    logic           sf_block;
    logic           lazy_block;

    always_comb begin
        pol = pick_policy(core);
        sf_block = core.exc == EXC_SECURE_FAULT && !core.prev_traced;
        lazy_block = core.exc == EXC_LAZY_FP &&
                     (!st_reg.ctrl[TRA_DATA_BIT] ||
                      (core.nid_secure_off && core.lazy_secure));
        take = core.valid && st_reg.ctrl[TRA_TRACE_BIT] &&
               !sf_block && !lazy_block;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.hready = 1'b1;
        st_next.elem.valid = 1'b0;
        if (take) begin
            st_next.elem.valid = 1'b1;
            st_next.elem.exc = core.exc;
            st_next.elem.addr = resolve_addr(core, pol);
            st_next.elem.addr_unknown = core.exc == EXC_RESET;
            st_next.elem.ctx_unknown = core.exc == EXC_RESET;
            st_next.elem.no_exec = core.exc == EXC_RESET ||
                                   (core.mcu && core.tail);
            st_next.elem.prev_unknown = core.exc == EXC_RESET;
            st_next.elem.handler_hidden = core.exc == EXC_SECURE_FAULT &&
                                          core.nid_secure_off;
            st_next.last_addr = resolve_addr(core, pol);
            st_next.count = st_reg.count + 16'h0001;
        end
        // Data phase of a write
        if (st_reg.dp_wr) begin
            if (st_reg.dp_addr == TRA_CTRL_OFS) begin
                st_next.ctrl = hwdata[1:0];
            end
            if (st_reg.dp_addr == TRA_COUNT_OFS) begin
                st_next.count = TRA_COUNT_RESET;
            end
        end
        st_next.dp_wr = 1'b0;
        // Address phase; reads sample now so the slave needs no wait state
        if (hsel && hready && htrans == TRA_HTRANS_NONSEQ) begin
            st_next.dp_wr = hwrite;
            st_next.dp_addr = haddr[7:0];
            st_next.hrdata = 32'h00000000;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    TRA_CTRL_OFS: st_next.hrdata = {30'h00000000, st_reg.ctrl};
                    TRA_COUNT_OFS: st_next.hrdata = {16'h0000, st_reg.count};
                    TRA_LAST_OFS: st_next.hrdata = st_reg.last_addr;
                    default: st_next.hrdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
            st_reg.ctrl <= TRA_CTRL_RESET;
            st_reg.count <= TRA_COUNT_RESET;
            st_reg.last_addr <= TRA_ADDR_RESET;
            st_reg.hready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hreadyout = st_reg.hready;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign elem = st_reg.elem;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic plain;
    assign plain = take && !(core.mcu && core.tail) && !core.ici_nz;

    a_reset_unknown: assert property (
        take && core.exc == EXC_RESET |=>
        elem.addr_unknown && elem.ctx_unknown && elem.no_exec)
        else $error("reset element not unknown");
    a_reset_prev: assert property (
        take && core.exc == EXC_RESET |=> elem.prev_unknown)
        else $error("reset prev target not marked");
    a_irq_next: assert property (
        plain && (core.exc == EXC_IRQ || core.exc == EXC_EXT_IRQ ||
                  core.exc == EXC_SYSTEM_TICK_EXCEPTION) |=>
        elem.addr == $past(core.addr_next))
        else $error("interrupt address wrong");
    a_trap_cause: assert property (
        plain && core.exc == EXC_TRAP |=> elem.addr == $past(core.addr_cause))
        else $error("trap address wrong");
    a_call_after: assert property (
        plain && core.exc == EXC_SUPERVISOR_CALL_EXCEPTION |=> elem.addr == $past(core.addr_call))
        else $error("call address wrong");
    a_fault_cause: assert property (
        plain && core.exc == EXC_DATA_FAULT |=>
        elem.addr == $past(core.addr_cause))
        else $error("fault address wrong");
    a_mcu_fault: assert property (
        plain && core.exc == EXC_USAGE_FAULT |=>
        elem.addr == $past(core.addr_cause))
        else $error("usage fault address wrong");
    a_bus_async: assert property (
        plain && core.exc == EXC_BUS_FAULT && !core.bus_sync |=>
        elem.addr == $past(core.addr_next))
        else $error("async bus fault address wrong");
    a_tail_fixed: assert property (
        take && core.mcu && core.tail && core.exc != EXC_RESET |=>
        elem.addr == TRA_TAIL_ADDR)
        else $error("tail-chained address not fixed");
    a_ici_step: assert property (
        take && core.exc == EXC_IRQ && core.ici_nz && !core.tail &&
        !core.insn32 |=> elem.addr == $past(core.addr_cause) + TRA_STEP_HALF)
        else $error("continuable step wrong");
    a_lockup_addr: assert property (
        take && !core.tail && core.exc == EXC_LOCKUP |=>
        elem.addr == $past(core.addr_lockup))
        else $error("lockup address wrong");
    a_sf_gate: assert property (
        core.valid && core.exc == EXC_SECURE_FAULT && !core.prev_traced |=>
        !elem.valid)
        else $error("secure fault traced alone");
    a_sf_hidden: assert property (
        take && core.exc == EXC_SECURE_FAULT && core.nid_secure_off |=>
        elem.handler_hidden)
        else $error("secure handler not hidden");
    a_lazy_data: assert property (
        core.valid && core.exc == EXC_LAZY_FP && !st_reg.ctrl[TRA_DATA_BIT]
        |=> !elem.valid)
        else $error("lazy push without data trace");
    a_lazy_secure: assert property (
        core.valid && core.exc == EXC_LAZY_FP && core.nid_secure_off &&
        core.lazy_secure |=> !elem.valid)
        else $error("secure lazy push traced");
    a_serr_elr: assert property (
        plain && core.exc == EXC_SYSTEM_ERROR && core.imprecise && !core.mcu &&
        core.to_64 |=> elem.addr == $past(core.exception_link_register))
        else $error("system error 64 address wrong");
    a_serr_lr: assert property (
        plain && core.exc == EXC_SYSTEM_ERROR && core.imprecise && !core.mcu &&
        !core.to_64 |=> elem.addr == $past(core.lr) - TRA_STEP_WORD)
        else $error("system error 32 address wrong");
    a_halt_dlr: assert property (
        plain && core.exc == EXC_DEBUG_HALT && (core.imprecise ||
        (!core.mcu && core.a64_cap)) |=> elem.addr == $past(core.debug_link_register))
        else $error("debug halt address wrong");

    // ----------------------------------------------------------------
    // Per-type address, flag and timing checks
    // ----------------------------------------------------------------
    a_fiq_next: assert property (
        plain && core.exc == EXC_FIQ |=>
        elem.addr == $past(core.addr_next))
        else $error("fiq address wrong");
    a_nmi_next: assert property (
        plain && core.exc == EXC_NMI |=>
        elem.addr == $past(core.addr_next))
        else $error("nmi address wrong");
    a_hard_next: assert property (
        plain && core.exc == EXC_HARD_FAULT |=>
        elem.addr == $past(core.addr_next))
        else $error("hard fault address wrong");
    a_pended_supervisor_call_next: assert property (
        plain && core.exc == EXC_PENDED_SUPERVISOR_CALL |=>
        elem.addr == $past(core.addr_next))
        else $error("pended call address wrong");
    a_monitor_next: assert property (
        plain && core.exc == EXC_DEBUG_MONITOR |=>
        elem.addr == $past(core.addr_next))
        else $error("monitor address wrong");
    a_lazy_next: assert property (
        plain && core.exc == EXC_LAZY_FP |=>
        elem.addr == $past(core.addr_next))
        else $error("lazy push address wrong");
    a_serr_precise: assert property (
        plain && core.exc == EXC_SYSTEM_ERROR && core.mcu |=>
        elem.addr == $past(core.addr_next))
        else $error("precise system error address wrong");
    a_halt_next: assert property (
        plain && core.exc == EXC_DEBUG_HALT && core.mcu && !core.imprecise |=>
        elem.addr == $past(core.addr_next))
        else $error("precise halt address wrong");
    a_trapped_cause: assert property (
        plain && core.exc == EXC_TRAPPED_EXC |=>
        elem.addr == $past(core.addr_cause))
        else $error("trapped exception address wrong");
    a_call_plain: assert property (
        plain && core.exc == EXC_CALL |=>
        elem.addr == $past(core.addr_call))
        else $error("call exception address wrong");
    a_inst_fault: assert property (
        plain && core.exc == EXC_INST_FAULT |=>
        elem.addr == $past(core.addr_cause))
        else $error("instruction fault address wrong");
    a_inst_debug: assert property (
        plain && core.exc == EXC_INST_DEBUG |=>
        elem.addr == $past(core.addr_cause))
        else $error("instruction debug address wrong");
    a_data_debug: assert property (
        plain && core.exc == EXC_DATA_DEBUG |=>
        elem.addr == $past(core.addr_cause))
        else $error("data debug address wrong");
    a_align_cause: assert property (
        plain && core.exc == EXC_ALIGNMENT |=>
        elem.addr == $past(core.addr_cause))
        else $error("alignment address wrong");
    a_mem_manage: assert property (
        plain && core.exc == EXC_MEM_MANAGE |=>
        elem.addr == $past(core.addr_cause))
        else $error("memory fault address wrong");
    a_bus_sync: assert property (
        plain && core.exc == EXC_BUS_FAULT && core.bus_sync |=>
        elem.addr == $past(core.addr_cause))
        else $error("sync bus fault address wrong");
    a_ici_plus4: assert property (
        take && core.exc == EXC_EXT_IRQ && core.ici_nz && !core.tail &&
        core.insn32 && core.ici_plus4 |=>
        elem.addr == $past(core.addr_cause) + TRA_STEP_WORD)
        else $error("continuable plus four wrong");
    a_ici_wide2: assert property (
        take && core.exc == EXC_NMI && core.ici_nz && !core.tail &&
        core.insn32 && !core.ici_plus4 |=>
        elem.addr == $past(core.addr_cause) + TRA_STEP_HALF)
        else $error("continuable wide plus two wrong");
    a_tail_noexec: assert property (
        take && core.mcu && core.tail |=> elem.no_exec)
        else $error("tail element shows execution");
    a_reset_addr: assert property (
        take && core.exc == EXC_RESET |=> elem.addr == TRA_ADDR_RESET)
        else $error("reset address not cleared");
    a_sf_taken: assert property (
        take && core.exc == EXC_SECURE_FAULT |=> elem.valid)
        else $error("secure fault dropped");
    a_sf_shown: assert property (
        take && core.exc == EXC_SECURE_FAULT && !core.nid_secure_off |=>
        !elem.handler_hidden)
        else $error("secure handler hidden needlessly");
    a_lazy_taken: assert property (
        take && core.exc == EXC_LAZY_FP |=> elem.valid)
        else $error("lazy push dropped");
    a_elem_timing: assert property (
        elem.valid |-> $past(take) && elem.exc == $past(core.exc))
        else $error("element not from previous cycle");

    c_reset: cover property (take && core.exc == EXC_RESET ##1 elem.valid);
    c_tail: cover property (take && core.mcu && core.tail);
    c_ici: cover property (take && core.ici_nz && core.insn32);
    c_read: cover property (hsel && htrans == TRA_HTRANS_NONSEQ && !hwrite);
    c_lazy: cover property (take && core.exc == EXC_LAZY_FP);
endmodule

/* File: bench/tra_core_model.sv */
// Purpose: behavioural model of the core reporting taken exceptions
// Assumes: one event held at a time; a new fire replaces a waiting one
// Notes:   delay sets how slowly the core reports; zero gives back to back
`timescale 1ns/1ps
module tra_core_model
    import tra_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         fire,
    input  wire tra_core_type pend,
    input  wire logic [3:0]   delay,
    output tra_core_type      core
);
    tra_core_type held;
    logic [3:0]   cnt;
    logic         armed;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core  <= '0;
            held  <= '0;
            cnt   <= 4'h0;
            armed <= 1'b0;
        end else begin
            core.valid <= 1'b0;
            if (armed && cnt == 4'h0) begin
                core       <= held;
                core.valid <= 1'b1;
                armed      <= 1'b0;
            end else if (armed) begin
                cnt <= cnt - 4'h1;
            end else if (core.valid) begin
                // Stale fields are scrambled so a picker that samples late is caught
                core       <= ~core;
                core.valid <= 1'b0;
            end
            if (fire) begin
                held  <= pend;
                cnt   <= delay;
                armed <= 1'b1;
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the return address picker
// Assumes: bus and events never overlap, so the trace enable is known
// Notes:   random events come from an LFSR seeded with 53
`timescale 1ns/1ps
module testbench
    import tra_pkg::*;
;
    logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic         fire = 1'b0, seen = 1'b0, hready, hreadyout, hresp;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd, last_exp = 32'h0;
    logic [31:0]  lfsr = 32'h00000035;
    logic [1:0]   htrans = 2'h0, ctrl_sh = 2'h0;
    logic [2:0]   hsize = 3'h2;
    logic [3:0]   dly = 4'h0;
    logic [7:0]   ofs [4] = '{TRA_CTRL_OFS, TRA_COUNT_OFS, TRA_LAST_OFS, 8'h0C};
    tra_core_type pend = '0, core, sc;
    tra_elem_type elem;
    int           errors = 0, checks_done = 0, n_exp = 0, cyc = 0;

    always #20 hclk = ~hclk;
    assign hready = hreadyout;

    tra_top i_tra_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .core(core), .elem(elem));
    tra_core_model i_tra_core_model (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .pend(pend), .delay(dly), .core(core));

    // ----------------------------------------------------------------
    // Checking and expectation
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [31:0] nxt();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic tra_core_type rand_core();
        logic [255:0] r;
        tra_core_type c;
        r = {nxt(), nxt(), nxt(), nxt(), nxt(), nxt(), nxt(), nxt()};
        c = r[$bits(tra_core_type)-1:0];
        c.valid = 1'b0;
        c.exc = tra_exc_type'(5'(nxt() % 32'h1A));
        // Tail chaining would mask most types, so keep it rare
        c.tail = c.tail & (nxt() % 32'h4 == 32'h0);
        if (!(c.exc inside {EXC_IRQ, EXC_EXT_IRQ, EXC_NMI}))
            c.ici_nz = 1'b0;
        return c;
    endfunction

    function automatic logic [31:0] exp_addr(input tra_core_type c);
        if (c.exc == EXC_RESET)
            return 32'h0;
        if (c.mcu && c.tail)
            return 32'h0FFFFFFE;
        if (c.ici_nz)
            return c.addr_cause + ((c.insn32 && c.ici_plus4) ? 32'h4 : 32'h2);
        case (c.exc)
            EXC_TRAP, EXC_TRAPPED_EXC, EXC_INST_FAULT, EXC_DATA_FAULT, EXC_INST_DEBUG,
            EXC_DATA_DEBUG, EXC_ALIGNMENT, EXC_MEM_MANAGE, EXC_USAGE_FAULT:
                return c.addr_cause;
            EXC_BUS_FAULT:
                return c.bus_sync ? c.addr_cause : c.addr_next;
            EXC_CALL, EXC_SUPERVISOR_CALL_EXCEPTION:
                return c.addr_call;
            EXC_SYSTEM_ERROR:
                if (c.imprecise && !c.mcu)
                    return c.to_64 ? c.exception_link_register : c.lr - 32'h4;
            EXC_DEBUG_HALT:
                if (c.imprecise || (!c.mcu && c.a64_cap))
                    return c.debug_link_register;
            EXC_LOCKUP:
                return c.addr_lockup;
            default: ;
        endcase
        return c.addr_next;
    endfunction

    function automatic logic traced(input tra_core_type c);
        if (c.exc == EXC_SECURE_FAULT && !c.prev_traced)
            return 1'b0;
        if (c.exc == EXC_LAZY_FP && (!ctrl_sh[1] || (c.nid_secure_off && c.lazy_secure)))
            return 1'b0;
        return ctrl_sh[0];
    endfunction

    always @(posedge hclk) begin
        seen <= core.valid === 1'b1;
        sc   <= core;
        cyc  <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end

    always @(negedge hclk) begin
        if (seen && traced(sc)) begin
            check("valid", {31'h0, elem.valid}, 32'h1);
            check("addr", elem.addr, exp_addr(sc));
            check("flags", {28'h0, elem.addr_unknown, elem.ctx_unknown, elem.no_exec,
                elem.prev_unknown}, (sc.exc == EXC_RESET) ? 32'hF :
                {30'h0, sc.mcu & sc.tail, 1'b0});
            check("exc", {27'h0, elem.exc}, {27'h0, sc.exc});
            check("hidden", {31'h0, elem.handler_hidden},
                {31'h0, sc.exc == EXC_SECURE_FAULT && sc.nid_secure_off});
            n_exp++;
            last_exp = exp_addr(sc);
        end else begin
            check("idle", {31'h0, elem.valid}, 32'h0);
        end
    end

    // ----------------------------------------------------------------
    // Bus and event drivers
    // ----------------------------------------------------------------
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge hclk);
        end
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr  <= {24'h0, a};
        hwrite <= w;
        hsel   <= 1'b1;
        htrans <= TRA_HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic ev(input tra_core_type c, input logic [3:0] d);
        pend <= c;
        dly  <= d;
        fire <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic quiet();
        fire <= 1'b0;
        repeat (20) @(posedge hclk);
    endtask

    initial begin
        tra_core_type c;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ofs[i]) begin
            xfer(ofs[i], 1'b0, 32'h0);
            check("reset value", rd, 32'h0);
        end
        xfer(TRA_LAST_OFS, 1'b1, 32'hFFFFFFFF);
        xfer(TRA_LAST_OFS, 1'b0, 32'h0);
        check("last read only", rd, 32'h0);
        $display("test registers done");
        repeat (3) ev(rand_core(), 4'h0);
        quiet();
        $display("test trace off done");
        for (int m = 1; m < 4; m += 2) begin
            xfer(TRA_CTRL_OFS, 1'b1, 32'(m));
            ctrl_sh = 2'(m);
            xfer(TRA_CTRL_OFS, 1'b0, 32'h0);
            check("ctrl", rd, 32'(m));
            // Runs of back to back events, the last of each run answered slowly
            for (int k = 0; k < 80; k++) begin
                ev(rand_core(), (k % 8 == 7) ? 4'(k % 16) : 4'h0);
                if (k % 8 == 7)
                    quiet();
            end
            c = rand_core();
            c.exc = EXC_RESET;
            ev(c, 4'h0);
            c.exc = EXC_SECURE_FAULT;
            c.prev_traced = 1'b0;
            ev(c, 4'h0);
            c.exc = EXC_LAZY_FP;
            c.nid_secure_off = 1'b1;
            c.lazy_secure = 1'b1;
            ev(c, 4'h0);
            c.exc = EXC_HARD_FAULT;
            c.mcu = 1'b1;
            c.tail = 1'b1;
            ev(c, 4'h0);
            quiet();
            xfer(TRA_COUNT_OFS, 1'b0, 32'h0);
            check("count", rd, {16'h0, n_exp[15:0]});
            xfer(TRA_LAST_OFS, 1'b0, 32'h0);
            check("last", rd, last_exp);
            xfer(TRA_COUNT_OFS, 1'b1, 32'h5);
            n_exp = 0;
            xfer(TRA_COUNT_OFS, 1'b0, 32'h0);
            check("count cleared", rd, 32'h0);
            $display("test events with ctrl %0d done", m);
        end
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        ctrl_sh = 2'h0;
        hresetn <= 1'b1;
        xfer(TRA_CTRL_OFS, 1'b0, 32'h0);
        check("ctrl after reset", rd, 32'h0);
        $display("test second reset done");
        report_and_stop();
    end
endmodule
